// >>> hw/nwf_pkg.sv
// Constants and types for the nested walk fault checker
package nwf_pkg;
    localparam int         ADDR_LSB    = 12;
    localparam int         IDX_W       = 9;
    localparam int         ENTRY_SHIFT = 3;
    localparam int         LIN_W       = 48;
    localparam int         GPA_W       = 52;
    localparam int         WORD_BYTES  = 4;
    localparam int         EXT_N       = 4;
    localparam int         EXT_SEL_LSB = 30;
    localparam int         REG_AW      = 8;
    localparam int         HTRANS_ACT  = 1;
    // Entry fields
    localparam int         PERM_R      = 0;
    localparam int         PERM_W      = 1;
    localparam int         PERM_X      = 2;
    localparam int         MT_LSB      = 3;
    localparam int         MT_W        = 3;
    localparam int         NTP_AD      = 6;
    localparam int         LEAF_BIT    = 7;
    localparam int         SVE_BIT     = 63;
    localparam int         G_PRESENT   = 0;
    localparam int         G_RW        = 1;
    localparam int         G_NX        = 63;
    localparam logic [2:0] MT_RSV_A    = 3'h2;
    localparam logic [2:0] MT_RSV_B    = 3'h3;
    localparam logic [2:0] MT_RSV_C    = 3'h7;
    localparam logic [2:0] PERM_ALL    = 3'h7;
    localparam logic [1:0] LVL_LAST    = 2'h0;
    localparam logic [1:0] LVL_DIR     = 2'h1;
    localparam logic [1:0] LVL_TOP     = 2'h3;
    // Register map
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_NTP_LO  = 8'h04;
    localparam logic [7:0] OFF_NTP_HI  = 8'h08;
    localparam logic [7:0] OFF_ROOT_LO = 8'h0c;
    localparam logic [7:0] OFF_ROOT_HI = 8'h10;
    localparam logic [7:0] OFF_EXT0    = 8'h14;
    localparam logic [7:0] OFF_STATUS  = 8'h24;
    localparam int         CTRL_PG     = 0;
    localparam int         CTRL_EXT    = 1;
    localparam int         CTRL_VE     = 2;
    localparam int         CTRL_W      = 3;
    localparam logic [2:0] CTRL_RESET  = 3'h0;
    localparam int         STAT_EXIT   = 2;
    localparam int         STAT_VE     = 3;
    localparam int         STAT_BUSY   = 4;

    typedef enum logic [1:0] {
        KIND_READ     = 2'h0,
        KIND_WRITE    = 2'h1,
        KIND_FETCH    = 2'h2,
        KIND_EXT_LOAD = 2'h3
    } nwf_kind_type;

    typedef enum logic [1:0] {
        CODE_OK         = 2'h0,
        CODE_MISCONFIG  = 2'h1,
        CODE_VIOLATION  = 2'h2,
        CODE_PAGE_FAULT = 2'h3
    } nwf_code_type;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_NSTART = 6'h02,
        ST_NCHK   = 6'h04,
        ST_GCHK   = 6'h08,
        ST_MEM    = 6'h10,
        ST_RESP   = 6'h20
    } nwf_state_type;
endpackage : nwf_pkg

// >>> hw/nwf_checker.sv
// Nested walk fault checker with AHB-Lite control registers
//
// Behaviour
// - Entry with bits 2:0 all zero is a violation even if misconfigured; otherwise misconfig wins over a denied leaf.
// - Nested entry with permission bits 2:0 all zero is a violation.
// - Data read needs read bit 0 set in every nested entry used.
// - Guest table entry reads are checked as data reads.
// - Data write needs write bit 1 set in every nested entry used.
// - Guest table flag updates are checked as data writes; the checker makes no flag updates.
// - Pointer bit 6 set makes guest table accesses checked as writes.
// - Extended-address register loads are always checked as reads.
// - Instruction fetch needs execute bit 2 set in every nested entry.
// - Nested walk starts at top level; bad present entry is misconfig.
// - Leaf is an entry below top level with bit 7, or last level; else descend.
// - Permissions judged only at final address; then access memory.
// - Guest walk starts at root pointer or selected extended register.
// - Guest entry fetch is nested-translated before its present bit.
// - Guest entry not present or with reserved bit gives page fault.
// - Guest leaf is a large-page entry below top level, or last level; else descend.
// - Guest privileges checked first at final address; deny is page fault.
// - Allowed final guest address is nested-translated, then accessed.
// - Guest paging off: linear address used directly, nested checks only.
// - Suppress bit ignored when exception conversion control is off.
// - Reserved bit or address bit above width set is misconfiguration.
// - Leaf memory type 2, 3 or 7 is misconfiguration.
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module nwf_checker #(
    parameter int PA_W = 40
) (
    input  logic                      hclk,
    input  logic                      hresetn,
    input  logic                      ce,
    input  logic                      hsel,
    input  logic [31:0]               haddr,
    input  logic [1:0]                htrans,
    input  logic                      hwrite,
    input  logic [2:0]                hsize,
    input  logic [31:0]               hwdata,
    input  logic                      hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    input  logic                      req_valid,
    input  nwf_pkg::nwf_kind_type     req_kind,
    input  logic [nwf_pkg::GPA_W-1:0] req_addr,
    output logic                      resp_valid,
    output nwf_pkg::nwf_code_type     resp_code,
    output logic [nwf_pkg::GPA_W-1:0] resp_paddr,
    output logic                      resp_exit,
    output logic                      resp_virt_exception,
    output logic                      mem_req,
    output logic                      mem_write,
    output logic [nwf_pkg::GPA_W-1:0] mem_addr,
    input  logic                      mem_ack,
    input  logic [63:0]               mem_rdata
);
    import nwf_pkg::*;

    if (PA_W <= ADDR_LSB || PA_W > GPA_W) begin : g_pa_w_check
        $error("PA_W out of range");
    end

    localparam logic [GPA_W-1:0] PA_MASK =
        GPA_W'((64'h1 << PA_W) - 64'h1);

    ////////////////////////////////////////////////////////////////////////
    // Address helpers

    function automatic logic [GPA_W-1:0] low_mask(input logic [1:0] lvl);
        low_mask = GPA_W'((64'h1 << (ADDR_LSB + IDX_W * int'(lvl))) - 64'h1);
    endfunction : low_mask

    function automatic logic [IDX_W-1:0] tbl_idx(
        input logic [GPA_W-1:0] a,
        input logic [1:0]       lvl
    );
        tbl_idx = IDX_W'(a >> (ADDR_LSB + IDX_W * int'(lvl)));
    endfunction : tbl_idx

    function automatic logic [GPA_W-1:0] entry_addr(
        input logic [GPA_W-1:0] base,
        input logic [GPA_W-1:0] a,
        input logic [1:0]       lvl
    );
        entry_addr = (base & PA_MASK & ~low_mask(LVL_LAST))
                   | GPA_W'({tbl_idx(a, lvl), ENTRY_SHIFT'(0)});
    endfunction : entry_addr

    function automatic logic [GPA_W-1:0] leaf_pa(
        input logic [GPA_W-1:0] e,
        input logic [GPA_W-1:0] a,
        input logic [1:0]       lvl
    );
        leaf_pa = (e & PA_MASK & ~low_mask(lvl)) | (a & low_mask(lvl));
    endfunction : leaf_pa

    function automatic logic rsv_hi(input logic [GPA_W-1:0] e);
        rsv_hi = |(e & ~PA_MASK);
    endfunction : rsv_hi

    function automatic logic nested_mis(
        input logic [63:0] e,
        input logic [1:0]  lvl,
        input logic        leaf
    );
        logic [MT_W-1:0] mt;
        mt = e[MT_LSB +: MT_W];
        nested_mis = rsv_hi(e[GPA_W-1:0])
            || (lvl == LVL_TOP && e[LEAF_BIT])
            || (!leaf && |e[LEAF_BIT-1:MT_LSB])
            || (leaf && |(e[GPA_W-1:0] & low_mask(lvl)
                          & ~low_mask(LVL_LAST)))
            || (leaf && (mt == MT_RSV_A || mt == MT_RSV_B
                         || mt == MT_RSV_C));
    endfunction : nested_mis

    function automatic logic perm_ok(
        input logic [2:0]   p,
        input nwf_kind_type k
    );
        unique case (k)
            KIND_WRITE: perm_ok = p[PERM_W];
            KIND_FETCH: perm_ok = p[PERM_X];
            default:    perm_ok = p[PERM_R];
        endcase
    endfunction : perm_ok

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus slave

    logic [CTRL_W-1:0]   ctrl_reg;
    logic [63:0]         ntp_reg;
    logic [63:0]         root_reg;
    logic [31:0]         ext_reg [EXT_N];
    logic                wr_pend_reg;
    logic [REG_AW-1:0]   wr_addr_reg;
    logic [31:0]         rd_data;
    logic [31:0]         status;
    nwf_state_type       state_reg;
    nwf_code_type        last_code_reg;
    logic                last_exit_reg;
    logic                last_ve_reg;
    logic                bus_take;

    assign bus_take = hsel && htrans[HTRANS_ACT] && hready;

    assign status = 32'({state_reg != ST_IDLE, last_ve_reg,
                         last_exit_reg, last_code_reg});

    always_comb begin
        rd_data = '0;
        case (haddr[REG_AW-1:0])
            OFF_CTRL:    rd_data = 32'(ctrl_reg);
            OFF_NTP_LO:  rd_data = ntp_reg[31:0];
            OFF_NTP_HI:  rd_data = ntp_reg[63:32];
            OFF_ROOT_LO: rd_data = root_reg[31:0];
            OFF_ROOT_HI: rd_data = root_reg[63:32];
            OFF_STATUS:  rd_data = status;
            default:     rd_data = '0;
        endcase
        for (int i = 0; i < EXT_N; i++) begin
            if (haddr[REG_AW-1:0] == OFF_EXT0 + REG_AW'(i * WORD_BYTES)) begin
                rd_data = ext_reg[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata      <= '0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else if (ce) begin
            wr_pend_reg <= bus_take && hwrite;
            if (bus_take) begin
                wr_addr_reg <= haddr[REG_AW-1:0];
                hrdata      <= hwrite ? 32'h0 : rd_data;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
            ntp_reg  <= '0;
            root_reg <= '0;
            for (int i = 0; i < EXT_N; i++) begin
                ext_reg[i] <= '0;
            end
        end else if (ce && wr_pend_reg) begin
            case (wr_addr_reg)
                OFF_CTRL:    ctrl_reg         <= hwdata[CTRL_W-1:0];
                OFF_NTP_LO:  ntp_reg[31:0]    <= hwdata;
                OFF_NTP_HI:  ntp_reg[63:32]   <= hwdata;
                OFF_ROOT_LO: root_reg[31:0]   <= hwdata;
                OFF_ROOT_HI: root_reg[63:32]  <= hwdata;
                default:     ;
            endcase
            for (int i = 0; i < EXT_N; i++) begin
                if (wr_addr_reg == OFF_EXT0 + REG_AW'(i * WORD_BYTES)) begin
                    ext_reg[i] <= hwdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry decode

    logic [GPA_W-1:0] ngpa_reg;
    logic [1:0]       nlvl_reg;
    logic [2:0]       nperm_reg;
    nwf_kind_type     nkind_reg;
    logic             final_reg;
    logic [1:0]       glvl_reg;
    logic             gw_reg;
    logic             gx_reg;

    logic [GPA_W-1:0] ent;
    logic [GPA_W-1:0] lin;
    logic             n_leaf;
    logic             n_absent;
    logic             n_mis;
    logic [2:0]       n_perm;
    logic             n_deny;
    logic             ve_take;
    logic             g_leaf;
    logic             g_bad;
    logic             g_w;
    logic             g_x;
    logic             g_deny;
    logic [1:0]       g_lvl0;
    logic [GPA_W-1:0] g_root;
    nwf_kind_type     walk_kind;

    assign ent = mem_rdata[GPA_W-1:0];
    assign lin = GPA_W'(req_addr[LIN_W-1:0]);
    assign n_leaf = nlvl_reg == LVL_LAST
                 || (nlvl_reg != LVL_TOP && mem_rdata[LEAF_BIT]);
    assign n_absent = mem_rdata[PERM_X:PERM_R] == 3'h0;
    assign n_mis = !n_absent && nested_mis(mem_rdata, nlvl_reg, n_leaf);
    assign n_perm = nperm_reg & mem_rdata[PERM_X:PERM_R];
    assign n_deny = !perm_ok(n_perm, nkind_reg);
    assign ve_take = ctrl_reg[CTRL_VE] && !mem_rdata[SVE_BIT];
    assign g_leaf = glvl_reg == LVL_LAST
                 || (glvl_reg != LVL_TOP && mem_rdata[LEAF_BIT]);
    assign g_bad = !mem_rdata[G_PRESENT] || rsv_hi(ent)
                || (glvl_reg == LVL_TOP && mem_rdata[LEAF_BIT]);
    assign g_w = gw_reg && mem_rdata[G_RW];
    assign g_x = gx_reg && !mem_rdata[G_NX];
    assign g_deny = (req_kind == KIND_WRITE && !g_w)
                 || (req_kind == KIND_FETCH && !g_x);
    assign g_lvl0 = ctrl_reg[CTRL_EXT] ? LVL_DIR : LVL_TOP;
    assign g_root = ctrl_reg[CTRL_EXT]
        ? GPA_W'(ext_reg[req_addr[EXT_SEL_LSB +: 2]])
        : root_reg[GPA_W-1:0];
    // Guest table accesses count as reads, or as writes with flags on
    assign walk_kind = ntp_reg[NTP_AD] ? KIND_WRITE
                                       : KIND_READ;

    ////////////////////////////////////////////////////////////////////////
    // Walk sequencer

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg           <= ST_IDLE;
            ngpa_reg            <= '0;
            nlvl_reg            <= LVL_TOP;
            nperm_reg           <= PERM_ALL;
            nkind_reg           <= KIND_READ;
            final_reg           <= 1'b0;
            glvl_reg            <= LVL_TOP;
            gw_reg              <= 1'b1;
            gx_reg              <= 1'b1;
            mem_req             <= 1'b0;
            mem_write           <= 1'b0;
            mem_addr            <= '0;
            resp_valid          <= 1'b0;
            resp_code           <= CODE_OK;
            resp_paddr          <= '0;
            resp_exit           <= 1'b0;
            resp_virt_exception <= 1'b0;
            last_code_reg       <= CODE_OK;
            last_exit_reg       <= 1'b0;
            last_ve_reg         <= 1'b0;
        end else if (ce) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (req_valid) begin
                        state_reg <= ST_NSTART;
                        final_reg <= 1'b1;
                        ngpa_reg  <= req_addr;
                        nkind_reg <= req_kind;
                        if (req_kind == KIND_EXT_LOAD) begin
                            nkind_reg <= KIND_READ;
                        end else if (ctrl_reg[CTRL_PG]) begin
                            final_reg <= 1'b0;
                            glvl_reg  <= g_lvl0;
                            gw_reg    <= 1'b1;
                            gx_reg    <= 1'b1;
                            nkind_reg <= walk_kind;
                            ngpa_reg  <= entry_addr(g_root, lin, g_lvl0);
                        end
                    end
                end
                ST_NSTART: begin
                    nlvl_reg  <= LVL_TOP;
                    nperm_reg <= PERM_ALL;
                    mem_req   <= 1'b1;
                    mem_write <= 1'b0;
                    mem_addr  <= entry_addr(ntp_reg[GPA_W-1:0], ngpa_reg,
                                            LVL_TOP);
                    state_reg <= ST_NCHK;
                end
                ST_NCHK: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        // First fault ends the walk
                        if (n_absent) begin
                            resp_code           <= CODE_VIOLATION;
                            resp_exit           <= !ve_take;
                            resp_virt_exception <= ve_take;
                            state_reg           <= ST_RESP;
                        end else if (n_mis) begin
                            resp_code           <= CODE_MISCONFIG;
                            resp_exit           <= 1'b1;
                            resp_virt_exception <= 1'b0;
                            state_reg           <= ST_RESP;
                        end else if (!n_leaf) begin
                            nlvl_reg  <= nlvl_reg - 2'h1;
                            nperm_reg <= n_perm;
                            mem_req   <= 1'b1;
                            mem_addr  <= entry_addr(ent, ngpa_reg,
                                                    nlvl_reg - 2'h1);
                        end else if (n_deny) begin
                            resp_code           <= CODE_VIOLATION;
                            resp_exit           <= !ve_take;
                            resp_virt_exception <= ve_take;
                            state_reg           <= ST_RESP;
                        end else begin
                            mem_req   <= 1'b1;
                            mem_addr  <= leaf_pa(ent, ngpa_reg, nlvl_reg);
                            mem_write <= final_reg
                                         && nkind_reg == KIND_WRITE;
                            state_reg <= final_reg ? ST_MEM
                                                   : ST_GCHK;
                        end
                    end
                end
                ST_GCHK: begin
                    if (mem_ack) begin
                        mem_req   <= 1'b0;
                        state_reg <= ST_NSTART;
                        if (g_bad || (g_leaf && g_deny)) begin
                            resp_code           <= CODE_PAGE_FAULT;
                            resp_exit           <= 1'b0;
                            resp_virt_exception <= 1'b0;
                            state_reg           <= ST_RESP;
                        end else if (g_leaf) begin
                            final_reg <= 1'b1;
                            nkind_reg <= req_kind;
                            ngpa_reg  <= leaf_pa(ent, lin, glvl_reg);
                        end else begin
                            glvl_reg  <= glvl_reg - 2'h1;
                            gw_reg    <= g_w;
                            gx_reg    <= g_x;
                            ngpa_reg  <= entry_addr(ent, lin,
                                                    glvl_reg - 2'h1);
                        end
                    end
                end
                ST_MEM: begin
                    if (mem_ack) begin
                        mem_req             <= 1'b0;
                        mem_write           <= 1'b0;
                        resp_code           <= CODE_OK;
                        resp_paddr          <= mem_addr;
                        resp_exit           <= 1'b0;
                        resp_virt_exception <= 1'b0;
                        state_reg           <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    if (!resp_valid) begin
                        resp_valid    <= 1'b1;
                        last_code_reg <= resp_code;
                        last_exit_reg <= resp_exit;
                        last_ve_reg   <= resp_virt_exception;
                    end else begin
                        resp_valid <= 1'b0;
                        state_reg  <= ST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : nwf_checker

// >>> verification/nwf_checker_props.sv
// Concurrent checks on the nested walk fault checker ports
`timescale 1ns/1ps
module nwf_checker_props
    import nwf_pkg::*;
#(
    parameter int PA_W = 40
) (
    input logic               hclk,
    input logic               hresetn,
    input logic               req_valid,
    input nwf_kind_type       req_kind,
    input logic               resp_valid,
    input nwf_code_type       resp_code,
    input logic               resp_exit,
    input logic               resp_virt_exception,
    input logic               mem_req,
    input logic               mem_write,
    input logic [GPA_W-1:0]   mem_addr,
    input logic               mem_ack
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_pulse: assert property (
        resp_valid |=> !resp_valid) else $error("Outcome pulse too long");
    a_resp_held: assert property (
        resp_valid |-> req_valid) else $error("Outcome without request");
    a_mis_exit: assert property (
        resp_valid && resp_code == CODE_MISCONFIG
        |-> resp_exit && !resp_virt_exception) else $error("Misconfig flags");
    a_viol_flags: assert property (
        resp_valid && resp_code == CODE_VIOLATION
        |-> resp_exit ^ resp_virt_exception) else $error("Violation flags");
    a_pf_no_exit: assert property (
        resp_valid && resp_code inside {CODE_OK, CODE_PAGE_FAULT}
        |-> !resp_exit && !resp_virt_exception) else $error("Exit flagged");
    a_mem_hold: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("Memory request dropped");
    a_write_kind: assert property (
        mem_req && mem_write |-> req_kind == KIND_WRITE)
        else $error("Write for non-write access");
    a_idle_quiet: assert property (
        !req_valid |-> !mem_req) else $error("Memory access while idle");

    cover property (resp_valid && resp_code == CODE_OK);
    cover property (resp_valid && resp_code == CODE_PAGE_FAULT);
    cover property (resp_valid && resp_virt_exception);
endmodule : nwf_checker_props

bind nwf_checker nwf_checker_props #(.PA_W(PA_W)) u_props (.*);

// >>> verification/nwf_mem_model.sv
// Table memory model answering walk and data requests
`timescale 1ns/1ps
module nwf_mem_model (
    input  logic                      hclk,
    input  logic                      mem_req,
    input  logic [nwf_pkg::GPA_W-1:0] mem_addr,
    output logic                      mem_ack,
    output logic [63:0]               mem_rdata
);
    logic [63:0] mem [logic [nwf_pkg::GPA_W-1:0]];
    int          lat = 0;
    int          cnt = 0;
    logic        hit;

    assign hit = mem_req && !mem_ack && cnt >= lat;
    initial begin
        mem_ack   = 1'b0;
        mem_rdata = 64'h0;
    end
    // Unlisted cells: present entry to page 0 with all access
    always @(posedge hclk) begin
        mem_ack   <= hit;
        mem_rdata <= !hit ? ~mem_rdata :
                     mem.exists(mem_addr) ? mem[mem_addr] : 64'h7;
        cnt       <= hit || !mem_req ? 0 : cnt + 1;
    end
endmodule : nwf_mem_model

// >>> verification/nwf_checker_test.sv
// Testbench for the nested walk fault checker
`timescale 1ns/1ps
module nwf_checker_test;
    import nwf_pkg::*;
    localparam logic [51:0] G   = 52'h0008080604123;
    localparam logic [3:0]  OK  = 4'h0;
    localparam logic [3:0]  MIS = {CODE_MISCONFIG, 2'b10};
    localparam logic [3:0]  VIO = {CODE_VIOLATION, 2'b10};
    localparam logic [3:0]  VE  = {CODE_VIOLATION, 2'b01};
    localparam logic [3:0]  PF  = {CODE_PAGE_FAULT, 2'b00};
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, req_valid = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
    logic [1:0] htrans = 0;
    nwf_kind_type req_kind = KIND_READ;
    nwf_code_type resp_code;
    logic [GPA_W-1:0] req_addr = 0, resp_paddr, mem_addr;
    logic hreadyout, hresp, resp_valid, resp_exit, resp_virt_exception;
    logic mem_req, mem_write, mem_ack;
    logic [63:0] mem_rdata;
    int bad_count = 0, check_count = 0;

    always #10 hclk = ~hclk;
    nwf_checker i_dut (.ce(1'b1), .hsize(3'h2), .hready(hreadyout), .*);
    nwf_mem_model mm (.*);
    ////////////////////////////////////////////////////////////////////
    task chk(input logic [63:0] g, input logic [63:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task req(input nwf_kind_type k, input logic [51:0] a,
             input logic [3:0] eo, input logic [51:0] ep);
        @(posedge hclk);
        req_valid <= 1;
        req_kind <= k;
        req_addr <= a;
        do @(posedge hclk); while (resp_valid !== 1'b1);
        req_valid <= 0;
        chk({resp_code, resp_exit, resp_virt_exception}, eo);
        if (eo == OK) chk(resp_paddr, ep);
        mm.mem.delete();
    endtask : req
    task complete_run;
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        complete_run;
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        bus(0, OFF_CTRL, 0);
        chk(rd, 0);
        bus(1, 8'h30, 32'hffffffff);
        bus(0, 8'h30, 0);
        chk(rd, 0);
        req(KIND_READ, G, OK, 52'h123);
        mm.lat = 2;
        mm.mem[32] = 64'h50000037;
        req(KIND_WRITE, G, OK, 52'h50000123);
        mm.mem[24] = 64'h400000b7;
        req(KIND_FETCH, G, OK, 52'h40004123);
        for (int k = 0; k < 3; k++) begin
            mm.mem[24] = 64'h7 ^ (64'h1 << k);
            req(nwf_kind_type'(k), G, VIO, 0);
        end
        mm.mem[8] = 64'h8000000000000000;
        req(KIND_READ, G, VIO, 0);
        bus(1, OFF_CTRL, 32'h4);
        mm.mem[8] = 0;
        req(KIND_READ, G, VE, 0);
        mm.mem[24] = 64'h200000000007;
        req(KIND_READ, G, MIS, 0);
        mm.mem[32] = 64'h17;
        req(KIND_WRITE, G, MIS, 0);
        mm.mem[32] = 64'h16;
        req(KIND_READ, G, MIS, 0);
        bus(0, OFF_STATUS, 0);
        chk(rd, 32'h5);
        bus(1, OFF_ROOT_LO, 32'h1000);
        bus(1, OFF_CTRL, 32'h1);
        mm.lat = 1;
        req(KIND_READ, G, OK, 52'h123);
        mm.mem[32] = 64'h5;
        req(KIND_WRITE, G, PF, 0);
        mm.mem[8] = 64'h1007;
        mm.mem[52'h1008] = 0;
        req(KIND_READ, G, PF, 0);
        mm.mem[52'h1008] = 0;
        mm.mem[8] = 0;
        req(KIND_READ, G, VIO, 0);
        mm.mem[8] = 64'h5;
        req(KIND_READ, G, OK, 52'h123);
        bus(1, OFF_NTP_LO, 32'h40);
        mm.mem[8] = 64'h5;
        req(KIND_READ, G, VIO, 0);
        mm.mem[8] = 64'h5;
        req(KIND_EXT_LOAD, 52'h1008, OK, 52'h8);
        bus(1, OFF_EXT0 + 8'h08, 32'h2000);
        bus(1, OFF_CTRL, 32'h3);
        mm.mem[16] = 64'h2007;
        mm.mem[52'h2018] = 0;
        req(KIND_READ, G, PF, 0);
        complete_run;
    end
endmodule : nwf_checker_test
